/* hdl/floppy_status_rate_regs.sv */
// floppy controller status, tape assignment and rate select registers
//
// Functional notes
// - tape register bits 7:6 ignore writes, read zero
// - bits 5:4 show selected drive's type
// - bits 3:2 mirror boot drive config
// - tape select bits stay read/write storage
// - status byte readable at offset 4 always
// - busy bits 3:0 mark seeking drives
// - bit 4 marks command in progress
// - bit 5 marks polled execution phase
// - bit 6 gives direction while request set
// - bit 7 permits host data transfer
// - writes at offset 4 hit rate select
// - latest rate or config write sets rate
// - hardware reset loads 02H, soft reset keeps
// - precomp field selects write data delay
// - precomp starts at programmable track, default 0
// - bit 6 enters low power until access
// - bit 7 pulses a self-clearing controller reset
// - rate codes decode per drive rate
// - density follows rate, polarity by option
// - output register bits 1:0 select drive
`timescale 1ns/100ps
module floppy_status_rate_regs
  import fdc_regs_pkg::*;
(
  input wire logic clock_in,                  // 40 MHz clock
  input wire logic rstn_in,                   // async reset, active low
  input wire logic [7:0] wb_adr_in,           // wishbone byte address
  input wire logic [31:0] wb_dat_in,          // wishbone write data
  input wire logic [3:0] wb_sel_in,           // wishbone byte lanes
  input wire logic wb_we_in,                  // wishbone write enable
  input wire logic wb_cyc_in,                 // wishbone cycle
  input wire logic wb_stb_in,                 // wishbone strobe
  output logic [31:0] wb_dat_out,             // wishbone read data
  output logic wb_ack_out,                    // wishbone acknowledge
  input wire engine_status_t engine_status_in,  // command engine state
  input wire logic data_reg_access_in,        // data register touched
  output logic ctrl_reset_out,                // controller soft reset
  output logic low_power_out,                 // manual low power
  output logic [1:0] rate_code_out,           // rate select pins
  output logic density_out,                   // density pin
  output logic [11:0] mfm_kbps_out,           // active mfm rate
  output logic [11:0] fm_kbps_out,            // active fm rate
  output logic [2:0] precomp_steps_out,       // write delay steps
  output logic [7:0] precomp_track_out,       // precomp start track
  output logic [1:0] drive_select_out,        // selected drive
  output logic [3:0] motor_enable_out,        // motor enables
  output logic dma_enable_out                 // dma logic enable
);
  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  wire logic [3:0] idx = wb_adr_in[5:2];
  wire logic in_range = (wb_adr_in[7:6] == 2'h0);
  wire logic req = wb_cyc_in && wb_stb_in;
  // writes and read side effects act on the edge that sees ack
  wire logic fire = req && wb_ack_out;
  wire logic wr_lane = fire && wb_we_in && wb_sel_in[0] && in_range;
  wire logic rd_fire = fire && !wb_we_in && in_range;
  wire logic [7:0] wbyte = wb_dat_in[7:0];

  wire logic wr_out_ctrl = wr_lane && reg_hit(idx, IDX_OUTPUT_CTRL);
  wire logic wr_tape = wr_lane && reg_hit(idx, IDX_TAPE_ASSIGN);
  // offset 4 writes land in rate select
  wire logic wr_rate_sel = wr_lane && reg_hit(idx, IDX_STATUS_RATE);
  wire logic wr_cfg_ctrl = wr_lane && reg_hit(idx, IDX_CONFIG_CTRL);
  wire logic wr_dtype = wr_lane && reg_hit(idx, IDX_DRIVE_TYPE);
  wire logic wr_boot = wr_lane && reg_hit(idx, IDX_BOOT_DRIVE);
  wire logic wr_opts = wr_lane && reg_hit(idx, IDX_OPTIONS);
  wire logic wr_track = wr_lane && reg_hit(idx, IDX_PRECOMP_TRACK);
  wire logic rd_status = rd_fire && reg_hit(idx, IDX_STATUS_RATE);

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  logic [7:0] output_control_reg;
  logic [1:0] tape_sel;
  logic [7:0] rate_precomp_select;
  logic [1:0] active_rate;
  logic [7:0] drive_type_config;
  logic [7:0] boot_drive_config;
  logic [3:0] options;
  logic [7:0] precomp_track;
  logic [2:0] swrst_count;
  logic density_armed;

  wire logic swrst_active = (swrst_count != 3'h0);
  wire logic enhanced = options[OPT_ENHANCED_BIT];
  wire drive_rate_code_t drive_rate = drive_rate_code_t'(options[3:2]);

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      output_control_reg <= OUT_CTRL_RESET;
      tape_sel <= 2'h0;
      drive_type_config <= 8'h00;
      boot_drive_config <= 8'h00;
      options <= OPTIONS_RESET;
      precomp_track <= PRECOMP_TRACK_RESET;
    end
    else
    begin
      if (wr_out_ctrl)
        output_control_reg <= wbyte;
      // tape select is plain storage in both layouts
      if (wr_tape)
        tape_sel <= wbyte[1:0];
      if (wr_dtype)
        drive_type_config <= wbyte;
      if (wr_boot)
        boot_drive_config <= wbyte;
      if (wr_opts)
        options <= wbyte[3:0];
      // start track defaults to 0, host may reprogram here
      if (wr_track)
        precomp_track <= wbyte;
    end
  end

  // -----------------------------------------------------------------
  // rate select and active rate
  // -----------------------------------------------------------------
  // soft reset does not touch these, only rstn_in does
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rate_precomp_select <= RATE_SEL_RESET;
      active_rate <= RATE_RESET;
    end
    else
    begin
      // bit 5 is stored as written; host keeps it zero
      if (wr_rate_sel)
        rate_precomp_select <= {2'h0, wbyte[5:0]};
      // whichever register was written last wins
      if (wr_rate_sel || wr_cfg_ctrl)
        active_rate <= wbyte[1:0];
    end
  end

  // -----------------------------------------------------------------
  // software reset and low power
  // -----------------------------------------------------------------
  // bit 7 starts a reset pulse that clears by itself
  // held for the same span a toggled output bit must give
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      swrst_count <= 3'h0;
    else if (wr_rate_sel && wbyte[RATE_SEL_SWRST_BIT])
      swrst_count <= SWRST_CYCLES;
    else if (swrst_active)
      swrst_count <= swrst_count - 3'h1;
  end

  wire logic next_ctrl_reset =
    !output_control_reg[OUT_CTRL_NRESET_BIT] || swrst_active;
  // any soft reset, data access or status read wakes it
  wire logic lp_set = wr_rate_sel && wbyte[RATE_SEL_LOWPWR_BIT];
  wire logic lp_clear = ctrl_reset_out || data_reg_access_in || rd_status;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      low_power_out <= 1'b0;
      ctrl_reset_out <= 1'b0;
    end
    else
    begin
      ctrl_reset_out <= next_ctrl_reset;
      // a new request wins over a wake in the same cycle
      if (lp_set)
        low_power_out <= 1'b1;
      else if (lp_clear)
        low_power_out <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // rate decode and pin outputs
  // -----------------------------------------------------------------
  logic [11:0] dec_kbps;
  logic dec_density;
  logic [2:0] dec_steps;

  rate_decode u_rate_decode (
    .rate_code_in(active_rate),
    .drive_rate_in(drive_rate),
    .write_delay_code_in(rate_precomp_select[4:2]),
    .ident_in(options[OPT_IDENT_BIT]),
    .mfm_kbps_out(dec_kbps),
    .density_level_out(dec_density),
    .precomp_steps_out(dec_steps)
  );

  // density stays high from hardware reset until a rate or option
  // write, since the reset rate alone would pull it low
  wire logic arm_density = wr_rate_sel || wr_cfg_ctrl || wr_opts;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      density_armed <= 1'b0;
      density_out <= 1'b1;
      mfm_kbps_out <= KBPS_250;
      fm_kbps_out <= 12'h000;
      precomp_steps_out <= PRECOMP_STEPS_OTHER;
      precomp_track_out <= PRECOMP_TRACK_RESET;
      rate_code_out <= RATE_RESET;
    end
    else
    begin
      if (arm_density)
        density_armed <= 1'b1;
      // soft resets have no effect on the pin
      density_out <= density_armed ? dec_density : 1'b1;
      // pins echo the code; fm runs at half the mfm rate
      rate_code_out <= active_rate;
      mfm_kbps_out <= dec_kbps;
      fm_kbps_out <= {1'b0, dec_kbps[11:1]};
      precomp_steps_out <= dec_steps;
      precomp_track_out <= precomp_track;
    end
  end

  // binary drive number in bits 1:0
  assign drive_select_out = output_control_reg[1:0];
  assign motor_enable_out = output_control_reg[7:4];
  assign dma_enable_out = output_control_reg[OUT_CTRL_DMAEN_BIT];

  // -----------------------------------------------------------------
  // read values
  // -----------------------------------------------------------------
  // drive n selects config bits 2n+1 and 2n
  wire logic [1:0] dtype_field =
    drive_type_config[{drive_select_out, 1'b0} +: 2];
  // boot drive field copies config bits 1:0
  wire logic [7:0] tape_value = enhanced ?
    {2'h0, dtype_field, boot_drive_config[1:0], tape_sel} :
    {6'h00, tape_sel};

  wire engine_status_t es = engine_status_in;
  wire logic [3:0] seek_bits = es.drive_seek_flag;
  // command busy from acceptance to end of results
  wire logic busy_bit = es.command_busy;
  // only in polled mode, only during execution
  wire logic non_dma_bit = es.polled_mode && es.exec_phase;
  // direction is meaningful only with a request
  wire logic dir_bit = es.host_request_flag && es.transfer_direction_flag;
  wire logic request_bit = es.host_request_flag;
  wire logic [7:0] status_value =
    {request_bit, dir_bit, non_dma_bit, busy_bit, seek_bits};

  wire logic [7:0] state_value =
    {swrst_active, low_power_out, density_out, 3'h0, active_rate};

  // status byte served at any time, after the one wait state
  wire logic [7:0] read_value =
    !in_range ? 8'h00 :
    reg_hit(idx, IDX_OUTPUT_CTRL) ? output_control_reg :
    reg_hit(idx, IDX_TAPE_ASSIGN) ? tape_value :
    reg_hit(idx, IDX_STATUS_RATE) ? status_value :
    reg_hit(idx, IDX_DRIVE_TYPE) ? drive_type_config :
    reg_hit(idx, IDX_BOOT_DRIVE) ? boot_drive_config :
    reg_hit(idx, IDX_OPTIONS) ? {4'h0, options} :
    reg_hit(idx, IDX_PRECOMP_TRACK) ? precomp_track :
    reg_hit(idx, IDX_BLOCK_STATE) ? state_value : 8'h00;

  // -----------------------------------------------------------------
  // bus answer
  // -----------------------------------------------------------------
  // one wait state; unmapped words ack and read zero
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_out <= req && !wb_ack_out;
      if (req && !wb_ack_out)
        wb_dat_out <= {24'h00_0000, read_value};
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  wire logic ack_rd = wb_ack_out && req && !wb_we_in && in_range;

  chk_tape_top_zero: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (ack_rd && idx == IDX_TAPE_ASSIGN) |-> (wb_dat_out[7:6] == 2'h0))
    else $error("tape register top bits not zero");

  chk_dtype_select: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (ack_rd && idx == IDX_TAPE_ASSIGN && enhanced && $stable(enhanced))
    |-> (wb_dat_out[5:4] == $past(dtype_field)))
    else $error("drive type field mismatch");

  chk_status_read: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (ack_rd && idx == IDX_STATUS_RATE)
    |-> (wb_dat_out[7:0] == $past(status_value)))
    else $error("status byte not returned");

  chk_dio_gated: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (ack_rd && idx == IDX_STATUS_RATE && !$past(es.host_request_flag))
    |-> (wb_dat_out[7:6] == 2'h0))
    else $error("direction shown without request");

  chk_reset_values: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (rstn_in && !$past(rstn_in)) |->
      (rate_precomp_select == RATE_SEL_RESET &&
      rate_code_out == RATE_RESET && density_out))
    else $error("hardware reset values wrong");

  chk_swrst_pulse: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (wr_rate_sel && wbyte[RATE_SEL_SWRST_BIT]) |=> swrst_active[*4] ##1
      (!swrst_active || $past(wr_rate_sel)))
    else $error("soft reset pulse length wrong");

  chk_lowpwr_wake: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    ((data_reg_access_in || rd_status) && !lp_set) |=> !low_power_out)
    else $error("low power not left on access");

  chk_rate_latest: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (wr_cfg_ctrl || wr_rate_sel) |-> ##2
      (rate_code_out == $past(wbyte[1:0], 2)))
    else $error("rate code not from latest write");
endmodule : floppy_status_rate_regs

/* hdl/fdc_regs_pkg.sv */
// shared constants and types for the floppy status and rate registers
package fdc_regs_pkg;
  // ---------------------------------------------------------------
  // register word indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_OUTPUT_CTRL = 4'h2;
  localparam logic [3:0] IDX_TAPE_ASSIGN = 4'h3;
  localparam logic [3:0] IDX_STATUS_RATE = 4'h4;
  localparam logic [3:0] IDX_CONFIG_CTRL = 4'h7;
  localparam logic [3:0] IDX_DRIVE_TYPE = 4'h8;
  localparam logic [3:0] IDX_BOOT_DRIVE = 4'h9;
  localparam logic [3:0] IDX_OPTIONS = 4'hA;
  localparam logic [3:0] IDX_PRECOMP_TRACK = 4'hB;
  localparam logic [3:0] IDX_BLOCK_STATE = 4'hC;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int RATE_SEL_SWRST_BIT = 7;
  localparam int RATE_SEL_LOWPWR_BIT = 6;
  localparam int OUT_CTRL_NRESET_BIT = 2;
  localparam int OUT_CTRL_DMAEN_BIT = 3;
  localparam int OPT_ENHANCED_BIT = 0;
  localparam int OPT_IDENT_BIT = 1;
  localparam logic [7:0] RATE_SEL_RESET = 8'h02;
  localparam logic [7:0] OUT_CTRL_RESET = 8'h00;
  localparam logic [1:0] RATE_RESET = 2'h2;
  localparam logic [7:0] PRECOMP_TRACK_RESET = 8'h00;
  localparam logic [3:0] OPTIONS_RESET = 4'h2;
  localparam logic [2:0] PRECOMP_DEFAULT = 3'h0;
  localparam logic [2:0] PRECOMP_NONE = 3'h7;
  localparam logic [2:0] PRECOMP_STEPS_1M = 3'h1;
  localparam logic [2:0] PRECOMP_STEPS_OTHER = 3'h3;
  localparam logic [11:0] KBPS_250 = 12'h0FA;
  localparam logic [11:0] KBPS_300 = 12'h12C;
  localparam logic [11:0] KBPS_500 = 12'h1F4;
  localparam logic [11:0] KBPS_1000 = 12'h3E8;
  localparam logic [11:0] KBPS_2000 = 12'h7D0;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SWRST_MIN_NS = 100;
  localparam int SWRST_CYCLES_INT =
    (SWRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SWRST_CYCLES = 3'(SWRST_CYCLES_INT);
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DRT_STANDARD = 2'b00,
    DRT_THREE_MODE = 2'b01,
    DRT_TAPE_2M = 2'b10,
    DRT_SPARE = 2'b11
  } drive_rate_code_t;

  typedef struct packed {
    logic host_request_flag;
    logic transfer_direction_flag;
    logic polled_mode;
    logic exec_phase;
    logic command_busy;
    logic [3:0] drive_seek_flag;
  } engine_status_t;

  function automatic logic reg_hit(input logic [3:0] idx,
                                   input logic [3:0] want);
    reg_hit = (idx == want);
  endfunction : reg_hit
endpackage : fdc_regs_pkg

/* hdl/rate_decode.sv */
// data rate, density and precompensation decode
`timescale 1ns/100ps
module rate_decode
  import fdc_regs_pkg::*;
(
  input wire logic [1:0] rate_code_in,         // active rate code
  input wire drive_rate_code_t drive_rate_in,  // drive rate setting
  input wire logic [2:0] write_delay_code_in,  // precomp field
  input wire logic ident_in,                   // density polarity option
  output logic [11:0] mfm_kbps_out,            // mfm rate in kbps
  output logic density_level_out,              // density pin level
  output logic [2:0] precomp_steps_out         // delay in 41.67 ns steps
);
  // -----------------------------------------------------------------
  // rate table
  // -----------------------------------------------------------------
  wire logic code01_500 = (drive_rate_in == DRT_THREE_MODE);
  wire logic code01_2m = (drive_rate_in == DRT_TAPE_2M);
  wire logic [11:0] code01_kbps =
    code01_2m ? KBPS_2000 : (code01_500 ? KBPS_500 : KBPS_300);
  // code to rate, drive rate alters code 01
  assign mfm_kbps_out =
    (rate_code_in == 2'h3) ? KBPS_1000 :
    (rate_code_in == 2'h0) ? KBPS_500 :
    (rate_code_in == 2'h1) ? code01_kbps : KBPS_250;

  // high-density codes are 11 and 00
  wire logic high_density = (rate_code_in == 2'h3) || (rate_code_in == 2'h0);
  assign density_level_out = ident_in ? high_density : !high_density;

  // code 000 picks the per-rate default, 111 disables
  wire logic [2:0] default_steps =
    (mfm_kbps_out == KBPS_1000) ? PRECOMP_STEPS_1M : PRECOMP_STEPS_OTHER;
  assign precomp_steps_out =
    (write_delay_code_in == PRECOMP_DEFAULT) ? default_steps :
    (write_delay_code_in == PRECOMP_NONE) ? 3'h0 : write_delay_code_in;
endmodule : rate_decode

/* bench/host_bus_model.sv */
// host processor model: classic wishbone master for the register bank
`timescale 1ns/100ps
module host_bus_model (
  input wire logic clock_in,        // bus clock
  input wire logic ack_in,          // slave acknowledge
  input wire logic [31:0] dat_in,   // slave read data
  output logic [7:0] adr_out,       // byte address
  output logic [31:0] dat_out,      // write data
  output logic [3:0] sel_out,       // byte lanes
  output logic we_out,              // write enable
  output logic cyc_out,             // cycle
  output logic stb_out              // strobe
);
  initial
  begin
    adr_out = 8'h00;
    dat_out = 32'h0;
    sel_out = 4'h0;
    we_out = 1'b0;
    cyc_out = 1'b0;
    stb_out = 1'b0;
  end

  // polls status, never touches data, bit 5 of rate select is 0
  task automatic access(input logic [7:0] a, input logic w,
                        input logic [7:0] d, output logic [31:0] q);
    @(posedge clock_in);
    adr_out <= a;
    dat_out <= {24'h0, (w && a == 8'h10) ? (d & 8'hDF) : d};
    sel_out <= 4'h1;
    we_out <= w;
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    // no cycle count is assumed; only the bench watchdog ends a hang
    do
      @(posedge clock_in);
    while (ack_in !== 1'b1);
    q = dat_in;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    we_out <= 1'b0;
  endtask : access
endmodule : host_bus_model

/* bench/test_floppy_status_rate_regs.sv */
// self-checking bench for the floppy status and rate register bank
`timescale 1ns/100ps
module test_floppy_status_rate_regs;
  import fdc_regs_pkg::*;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [3:0] sel;
  logic we;
  logic cyc;
  logic stb;
  logic ack;
  engine_status_t engine = '0;
  logic data_access = 1'b0;
  logic ctrl_reset;
  logic low_power;
  logic [1:0] rate_code;
  logic density;
  logic [11:0] mfm;
  logic [11:0] fm;
  logic [2:0] steps;
  logic [7:0] track;
  logic [1:0] drive_sel;
  logic [3:0] motor;
  logic dma;
  logic [31:0] rd;
  int failures = 0;
  int check_count = 0;

  always #12.5 clock_in = ~clock_in;

  host_bus_model i_host (.clock_in(clock_in), .ack_in(ack), .dat_in(rdat),
    .adr_out(adr), .dat_out(wdat), .sel_out(sel), .we_out(we),
    .cyc_out(cyc), .stb_out(stb));

  floppy_status_rate_regs i_dut (.clock_in(clock_in), .rstn_in(rstn_in),
    .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel), .wb_we_in(we),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_dat_out(rdat), .wb_ack_out(ack),
    .engine_status_in(engine), .data_reg_access_in(data_access),
    .ctrl_reset_out(ctrl_reset), .low_power_out(low_power),
    .rate_code_out(rate_code), .density_out(density), .mfm_kbps_out(mfm),
    .fm_kbps_out(fm), .precomp_steps_out(steps), .precomp_track_out(track),
    .drive_select_out(drive_sel), .motor_enable_out(motor),
    .dma_enable_out(dma));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.access(a, 1'b1, d, rd);
  endtask : wr

  task automatic rd_val(input logic [7:0] a);
    i_host.access(a, 1'b0, 8'h00, rd);
  endtask : rd_val

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tick

  function automatic logic [11:0] kbps(input logic [1:0] c,
                                       input logic [1:0] drt);
    case (c)
      2'b11: kbps = 12'h3E8;
      2'b00: kbps = 12'h1F4;
      2'b10: kbps = 12'h0FA;
      default: kbps = (drt == 2'b01) ? 12'h1F4 :
                      (drt == 2'b10) ? 12'h7D0 : 12'h12C;
    endcase
  endfunction : kbps

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(rate_code, 2'b10);
    chk(mfm, 12'h0FA);
    chk(density, 1'b1);
    chk(steps, 3'h3);
    chk(ctrl_reset, 1'b1);
    chk(track, 8'h00);
    wr(8'h2C, 8'h50);
    wr(8'h08, 8'hAC);
    tick(3);
    chk(track, 8'h50);
    chk(ctrl_reset, 1'b0);
    chk({motor, dma}, 5'h15);
    rd_val(8'h1C);
    chk(rd, 32'h0);
    wr(8'hC0, 8'hFF);
    rd_val(8'hC0);
    chk(rd, 32'h0);
    rd_val(8'h34);
    chk(rd, 32'h0);
  endtask : t_reset

  task automatic t_tape();
    wr(8'h28, 8'h03);
    wr(8'h20, 8'hE4);
    wr(8'h24, 8'h02);
    wr(8'h0C, 8'hFF);
    for (int d = 0; d < 4; d++)
    begin
      wr(8'h08, 8'(d + 4));
      rd_val(8'h0C);
      chk(rd, d * 16 + 11);
      chk(drive_sel, d);
    end
    wr(8'h28, 8'h02);
    rd_val(8'h0C);
    chk(rd, 32'h03);
  endtask : t_tape

  task automatic t_status();
    logic [8:0] pat [6] = '{9'h1FF, 9'h0FF, 9'h155, 9'h0AA, 9'h13F, 9'h0};
    logic [8:0] p;
    foreach (pat[i])
    begin
      p = pat[i];
      engine <= p;
      rd_val(8'h10);
      chk(rd, {p[8], p[8] & p[7], p[6] & p[5], p[4:0]});
    end
  endtask : t_status

  task automatic t_rate();
    for (int drt = 0; drt < 4; drt++)
      for (int c = 0; c < 4; c++)
      begin
        wr(8'h28, 8'(drt * 4 + 3));
        wr(8'h10, 8'(c));
        tick(3);
        chk(rate_code, c);
        chk(mfm, kbps(2'(c), 2'(drt)));
        chk(fm, kbps(2'(c), 2'(drt)) >> 1);
        chk(density, c == 0 || c == 3);
        chk(steps, c == 3 ? 1 : 3);
      end
    wr(8'h1C, 8'h01);
    tick(3);
    chk(rate_code, 2'b01);
    wr(8'h10, 8'h02);
    wr(8'h28, 8'h01);
    tick(3);
    chk(rate_code, 2'b10);
    chk(density, 1'b1);
    wr(8'h10, 8'h03);
    tick(3);
    chk(density, 1'b0);
  endtask : t_rate

  task automatic t_precomp();
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h10, 8'(c * 4 + 2));
      tick(3);
      chk(steps, c == 7 ? 0 : c == 0 ? 3 : c);
    end
  endtask : t_precomp

  task automatic t_soft_reset();
    int n;
    n = 0;
    wr(8'h10, 8'h80);
    repeat (12)
    begin
      @(posedge clock_in);
      n += (ctrl_reset === 1'b1);
    end
    chk(n, 4);
    wr(8'h10, 8'h0F);
    wr(8'h08, 8'h00);
    tick(3);
    chk(ctrl_reset, 1'b1);
    wr(8'h08, 8'h04);
    tick(3);
    chk({ctrl_reset, rate_code, steps}, {1'b0, 2'b11, 3'h3});
  endtask : t_soft_reset

  task automatic t_low_power();
    wr(8'h10, 8'h42);
    tick(3);
    chk(low_power, 1'b1);
    data_access <= 1'b1;
    @(posedge clock_in);
    data_access <= 1'b0;
    tick(3);
    chk(low_power, 1'b0);
    wr(8'h10, 8'h42);
    rd_val(8'h10);
    tick(3);
    chk(low_power, 1'b0);
    wr(8'h10, 8'hC2);
    tick(10);
    chk(low_power, 1'b0);
    rd_val(8'h30);
    chk(rd, 32'h22);
  endtask : t_low_power

  task automatic t_hw_reset();
    wr(8'h10, 8'h00);
    rstn_in <= 1'b0;
    tick(4);
    rstn_in <= 1'b1;
    tick(2);
    chk({rate_code, density}, 3'b101);
  endtask : t_hw_reset

  task automatic results();
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  initial
  begin
    tick(16);
    rstn_in <= 1'b1;
    tick(2);
    t_reset();
    t_tape();
    t_status();
    t_rate();
    t_precomp();
    t_soft_reset();
    t_low_power();
    t_hw_reset();
    results();
  end

  // the whole sequence needs well under 2000 cycles
  initial
  begin
    tick(20000);
    failures++;
    results();
  end
endmodule : test_floppy_status_rate_regs
